// ==== core/mcor_regs.vh ====
// Register offsets, field positions and reset values for the monitor
// configuration and offset registers. Definitions only.
`ifndef MCOR_REGS_VH
`define MCOR_REGS_VH

`define MCOR_ADDR_TREE_TEST 8'h6f
`define MCOR_ADDR_OFS_REMOTE_ONE 8'h70
`define MCOR_ADDR_OFS_ONCHIP 8'h71
`define MCOR_ADDR_OFS_REMOTE_TWO 8'h72
`define MCOR_ADDR_CONFIG_TWO 8'h73

`define MCOR_RST_TREE_TEST 8'h00
`define MCOR_RST_OFFSET 8'h00
`define MCOR_RST_CONFIG_TWO 8'h00

`define MCOR_BIT_TREE_ON 0
`define MCOR_BIT_SENSE_LO 0
`define MCOR_BIT_SENSE_HI 3
`define MCOR_BIT_AVG_OFF 4
`define MCOR_BIT_ATTENUATOR_BYPASS_BYP 5
`define MCOR_BIT_SINGLE 6
`define MCOR_BIT_SHUTDOWN_REQUEST 7

`define MCOR_SEL_LO 5
`define MCOR_SEL_HI 7
`define MCOR_CH_CORE_V 3'h1
`define MCOR_CH_SUPPLY 3'h2
`define MCOR_CH_REMOTE_ONE 3'h5
`define MCOR_CH_ONCHIP 3'h6
`define MCOR_CH_REMOTE_TWO 3'h7

`define MCOR_DUTY_OFF 8'h00
`define MCOR_AVG_COUNT 8'h10

`endif

// ==== core/mcor_offset_add.v ====
// Adds a signed half-degree offset to one signed quarter-degree reading.
// Assumes raw readings and their valid pulse come from logic on clk.
`timescale 1ns/1ps
`include "mcor_regs.vh"

module mcor_offset_add #(
  parameter TW = 10
) (
  input wire clk,
  input wire rst,
  input wire [TW-1:0] raw_temp,
  input wire raw_valid,
  input wire [7:0] offset,
  output reg [TW-1:0] temp_out,
  output reg temp_valid
);

  wire signed [TW+1:0] raw_ext = {{2{raw_temp[TW-1]}}, raw_temp};
  // Offset step is two reading steps, hence the shift
  wire signed [TW+1:0] ofs_ext = {{(TW-7){offset[7]}}, offset, 1'b0};
  wire signed [TW+1:0] sum = raw_ext + ofs_ext;
  wire [TW-1:0] max_pos = {1'b0, {(TW-1){1'b1}}};
  wire [TW-1:0] max_neg = {1'b1, {(TW-1){1'b0}}};
  reg [TW-1:0] next_temp;

  // Saturate rather than wrap so a hot sensor never reads cold
  always @* begin
    if (sum[TW+1] && !(&sum[TW:TW-1]))
      next_temp = max_neg;
    else if (!sum[TW+1] && (|sum[TW:TW-1]))
      next_temp = max_pos;
    else
      next_temp = sum[TW-1:0];
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_out <= {TW{1'b0}};
      temp_valid <= 1'b0;
    end else begin
      temp_valid <= raw_valid;
      if (raw_valid)
        temp_out <= next_temp;
    end
  end

endmodule // mcor_offset_add

// ==== core/mcor_single_channel_convert_seq.v ====
// Conversion sequencer: round robin over all inputs or one fixed input.
// Assumes single_channel_convert_done is a one-cycle pulse from the converter on clk.
`timescale 1ns/1ps
`include "mcor_regs.vh"

module mcor_single_channel_convert_seq #(
  parameter [7:0] AVG_COUNT = `MCOR_AVG_COUNT
) (
  input wire clk,
  input wire rst,
  input wire run,
  input wire single_mode,
  input wire [2:0] single_code,
  input wire avg_off,
  input wire single_channel_convert_done,
  output reg single_channel_convert_start,
  output reg [2:0] single_channel_convert_chan,
  output reg slot_done
);

  localparam S_IDLE = 2'd0;
  localparam S_START = 2'd1;
  localparam S_WAIT = 2'd2;

  reg [1:0] state;
  reg [7:0] reps;

  function is_valid_code;
    input [2:0] code;
    begin
      is_valid_code = (code == `MCOR_CH_CORE_V) || (code == `MCOR_CH_SUPPLY) ||
                      (code[2] && (code != 3'h4));
    end
  endfunction

  function [2:0] next_in_ring;
    input [2:0] code;
    begin
      case (code)
        `MCOR_CH_CORE_V: next_in_ring = `MCOR_CH_SUPPLY;
        `MCOR_CH_SUPPLY: next_in_ring = `MCOR_CH_REMOTE_ONE;
        `MCOR_CH_REMOTE_ONE: next_in_ring = `MCOR_CH_ONCHIP;
        `MCOR_CH_ONCHIP: next_in_ring = `MCOR_CH_REMOTE_TWO;
        default: next_in_ring = `MCOR_CH_CORE_V;
      endcase
    end
  endfunction

  wire [2:0] first_chan = single_mode ? single_code : `MCOR_CH_CORE_V;
  wire [7:0] need = avg_off ? 8'h01 : AVG_COUNT;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      reps <= 8'h00;
      single_channel_convert_start <= 1'b0;
      single_channel_convert_chan <= `MCOR_CH_CORE_V;
      slot_done <= 1'b0;
    end else begin
      single_channel_convert_start <= 1'b0;
      slot_done <= 1'b0;
      case (state)
        S_IDLE: begin
          // Reserved single codes leave the converter idle
          if (run && (!single_mode || is_valid_code(single_code))) begin
            single_channel_convert_chan <= first_chan;
            reps <= 8'h00;
            state <= S_START;
          end
        end
        S_START: begin
          single_channel_convert_start <= 1'b1;
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (single_channel_convert_done) begin
            if (reps + 8'h01 >= need) begin
              slot_done <= 1'b1;
              reps <= 8'h00;
              if (!run || (single_mode && !is_valid_code(single_code)))
                state <= S_IDLE;
              else begin
                single_channel_convert_chan <= single_mode ? single_code : next_in_ring(single_channel_convert_chan);
                state <= S_START;
              end
            end else begin
              reps <= reps + 8'h01;
              state <= S_START;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // mcor_single_channel_convert_seq

// ==== core/mcor_top.v ====
// Test enable, temperature offset and second configuration registers,
// with the logic they steer: offsets, sequencing, shutdown, sensing.
// Assumes the serial port, converter and PWM engine share clk.
`timescale 1ns/1ps
`include "mcor_regs.vh"

module mcor_top #(
  parameter TW = 10,
  parameter NPWM = 3,
  parameter NFAN = 4,
  parameter [7:0] AVG_COUNT = `MCOR_AVG_COUNT
) (
  input wire clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire cfg_lock,
  output reg [7:0] reg_rdata,
  output reg reg_hit,
  input wire [7:0] tach1_min_hi,
  input wire low_freq_mode,
  input wire pwm_polarity_invert,
  input wire [NPWM-1:0] pwm_drive,
  input wire [8*NPWM-1:0] duty_now,
  output reg [NPWM-1:0] pwm_out,
  output reg [8*NPWM-1:0] duty_read,
  input wire [3*TW-1:0] raw_temp,
  input wire [2:0] raw_valid,
  output wire [3*TW-1:0] temp_corr,
  output wire [2:0] temp_valid,
  input wire single_channel_convert_done,
  output wire single_channel_convert_start,
  output wire [2:0] single_channel_convert_chan,
  output wire slot_done,
  output wire tree_test_on,
  output wire [NFAN-1:0] fan_two_wire_sense,
  output wire averaging_off,
  output wire attenuator_bypass,
  output wire core_voltage_input,
  output wire single_channel_convert,
  output wire shutdown_request
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  reg tree_bit;
  reg [7:0] ofs_remote_one;
  reg [7:0] ofs_onchip;
  reg [7:0] ofs_remote_two;
  reg [7:0] cfg_two;

  // One decode per register, shared by write and read paths
  function [4:0] decode;
    input [7:0] a;
    begin
      decode[0] = (a == `MCOR_ADDR_TREE_TEST);
      decode[1] = (a == `MCOR_ADDR_OFS_REMOTE_ONE);
      decode[2] = (a == `MCOR_ADDR_OFS_ONCHIP);
      decode[3] = (a == `MCOR_ADDR_OFS_REMOTE_TWO);
      decode[4] = (a == `MCOR_ADDR_CONFIG_TWO);
    end
  endfunction

  wire [4:0] sel = decode(reg_addr);
  // Lock turns the whole bank read-only
  wire wr_ok = reg_wr && !cfg_lock;

  ////////////////////////////////////////////////////////////////////////
  // Write path

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tree_bit <= 1'b0;
      ofs_remote_one <= `MCOR_RST_OFFSET;
      ofs_onchip <= `MCOR_RST_OFFSET;
      ofs_remote_two <= `MCOR_RST_OFFSET;
      cfg_two <= `MCOR_RST_CONFIG_TWO;
    end else if (wr_ok) begin
      if (sel[0])
        // Unused upper bits are not stored
        tree_bit <= reg_wdata[`MCOR_BIT_TREE_ON];
      if (sel[1])
        ofs_remote_one <= reg_wdata;
      if (sel[2])
        ofs_onchip <= reg_wdata;
      if (sel[3])
        ofs_remote_two <= reg_wdata;
      if (sel[4])
        cfg_two <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the read strobe

  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    case (1'b1)
      sel[0]: next_rdata = {7'h00, tree_bit};
      sel[1]: next_rdata = ofs_remote_one;
      sel[2]: next_rdata = ofs_onchip;
      sel[3]: next_rdata = ofs_remote_two;
      sel[4]: next_rdata = cfg_two;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else begin
      reg_hit <= reg_rd && (|sel);
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode outputs

  assign tree_test_on = tree_bit;
  assign averaging_off = cfg_two[`MCOR_BIT_AVG_OFF];
  assign attenuator_bypass = cfg_two[`MCOR_BIT_ATTENUATOR_BYPASS_BYP];
  // Core input runs without attenuation when bypassed
  assign core_voltage_input = !cfg_two[`MCOR_BIT_ATTENUATOR_BYPASS_BYP];
  assign single_channel_convert = cfg_two[`MCOR_BIT_SINGLE];
  assign shutdown_request = cfg_two[`MCOR_BIT_SHUTDOWN_REQUEST];

  // Two-wire sensing only matters with low frequency drive
  genvar f;
  generate
    for (f = 0; f < NFAN; f = f + 1) begin : g_sense
      assign fan_two_wire_sense[f] =
        cfg_two[`MCOR_BIT_SENSE_LO + f] && low_freq_mode;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Offset correction ahead of storage, limits and fan loops

  wire [23:0] ofs_all = {ofs_remote_two, ofs_onchip, ofs_remote_one};

  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_ofs
      mcor_offset_add #(
        .TW(TW)
      ) u_add (
        .clk(clk),
        .rst(rst),
        .raw_temp(raw_temp[c*TW +: TW]),
        .raw_valid(raw_valid[c]),
        .offset(ofs_all[c*8 +: 8]),
        .temp_out(temp_corr[c*TW +: TW]),
        .temp_valid(temp_valid[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencing

  // Shutdown stops conversions; selected code from tach one minimum high
  wire [2:0] single_code = tach1_min_hi[`MCOR_SEL_HI:`MCOR_SEL_LO];

  mcor_single_channel_convert_seq #(
    .AVG_COUNT(AVG_COUNT)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .run(!shutdown_request),
    .single_mode(single_channel_convert),
    .single_code(single_code),
    .avg_off(averaging_off),
    .single_channel_convert_done(single_channel_convert_done),
    .single_channel_convert_start(single_channel_convert_start),
    .single_channel_convert_chan(single_channel_convert_chan),
    .slot_done(slot_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shutdown of PWM drive and duty readback

  // Fan-off level is low, or high under inversion
  wire off_level = pwm_polarity_invert;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_out <= {NPWM{1'b0}};
      duty_read <= {(8*NPWM){1'b0}};
    end else if (shutdown_request) begin
      pwm_out <= {NPWM{off_level}};
      duty_read <= {NPWM{`MCOR_DUTY_OFF}};
    end else begin
      pwm_out <= pwm_drive;
      duty_read <= duty_now;
    end
  end

endmodule // mcor_top

// ==== tb/mcor_checker.sv ====
// Concurrent checks for the configuration and offset register block.
// Assumes one clock domain; bound into every mcor_top instance.
`timescale 1ns/1ps
module mcor_checker #(
  parameter TW = 10,
  parameter NPWM = 3,
  parameter NFAN = 4
) (
  input wire clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire cfg_lock,
  input wire [7:0] reg_rdata,
  input wire reg_hit,
  input wire low_freq_mode,
  input wire pwm_polarity_invert,
  input wire [NPWM-1:0] pwm_drive,
  input wire [8*NPWM-1:0] duty_now,
  input wire [NPWM-1:0] pwm_out,
  input wire [8*NPWM-1:0] duty_read,
  input wire [2:0] raw_valid,
  input wire [2:0] temp_valid,
  input wire tree_test_on,
  input wire [NFAN-1:0] fan_two_wire_sense,
  input wire averaging_off,
  input wire attenuator_bypass,
  input wire core_voltage_input,
  input wire single_channel_convert,
  input wire shutdown_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  tree_mode_a: assert property (
    reg_wr && !cfg_lock && reg_addr == 8'h6f |=> tree_test_on == $past(reg_wdata[0]))
    else $error("tree test bit not stored");
  test_upper_a: assert property (
    reg_rd && reg_addr == 8'h6f |=> reg_hit && reg_rdata[7:1] == 7'h00)
    else $error("test register upper bits not zero");
  lock_hold_a: assert property (
    reg_wr && cfg_lock |=> $stable({tree_test_on, averaging_off, attenuator_bypass,
    single_channel_convert, shutdown_request})) else $error("locked write changed state");
  cfg_store_a: assert property (
    reg_wr && !cfg_lock && reg_addr == 8'h73 |=> {shutdown_request, single_channel_convert,
    attenuator_bypass, averaging_off} == $past(reg_wdata[7:4])) else $error("config not stored");
  sense_gate_a: assert property (
    !low_freq_mode |-> fan_two_wire_sense == {NFAN{1'b0}}) else $error("2-wire sense outside lf");
  shutdown_request_pwm_a: assert property (
    shutdown_request |=> pwm_out == {NPWM{$past(pwm_polarity_invert)}})
    else $error("pwm not at fan-off level");
  shutdown_request_duty_a: assert property (
    shutdown_request |=> duty_read == {8*NPWM{1'b0}}) else $error("duty readback not zero");
  run_pass_a: assert property (
    !shutdown_request |=> pwm_out == $past(pwm_drive) && duty_read == $past(duty_now))
    else $error("pwm or duty not passed through");
  temp_pulse_a: assert property (
    raw_valid != 3'h0 |=> temp_valid == $past(raw_valid)) else $error("corrected pulse lost");
  core_input_a: assert property (
    core_voltage_input == !attenuator_bypass) else $error("attenuator state wrong");
endmodule // mcor_checker

bind mcor_top mcor_checker #(.TW(TW), .NPWM(NPWM), .NFAN(NFAN)) mcor_checker_inst (.*);

// ==== tb/tb.sv ====
// Self-checking bench for the configuration and offset register block.
// Drives all inputs at the falling edge; design built with AVG_COUNT of 2.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb;
  reg clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cfg_lock = 0, low_freq_mode = 0;
  reg pwm_polarity_invert = 0, single_channel_convert_done = 0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tach1_min_hi = 8'h00;
  reg [2:0] pwm_drive = 3'h5, raw_valid = 3'h0;
  reg [23:0] duty_now = 24'h123456;
  reg [29:0] raw_temp = 30'h0;
  // Round-robin order of the valid channel codes
  function [2:0] ring_at(input integer i);
    case (i)
      0: ring_at = 3'h1;
      1: ring_at = 3'h2;
      2: ring_at = 3'h5;
      3: ring_at = 3'h6;
      default: ring_at = 3'h7;
    endcase
  endfunction
  wire [7:0] reg_rdata;
  wire [2:0] pwm_out, temp_valid, single_channel_convert_chan;
  wire [23:0] duty_read;
  wire [29:0] temp_corr;
  wire [3:0] fan_two_wire_sense;
  wire reg_hit, single_channel_convert_start, slot_done, tree_test_on, averaging_off, attenuator_bypass;
  wire core_voltage_input, single_channel_convert, shutdown_request;
  integer n_fail = 0, comparisons = 0, k, n;
  mcor_top #(.AVG_COUNT(8'h02)) mcor_top_inst (.*);
  always #10 clk = ~clk;
  // One-cycle converter stand-in keeps the sequencer moving
  always @(negedge clk) single_channel_convert_done <= single_channel_convert_start;
  ////////////////////////////////////////////////////////////////
  // Each access ends with an idle edge so back-to-back calls never
  // lower and raise a strobe in the same time step
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge clk);
      reg_wr = 0;
      @(negedge clk);
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      reg_addr = a;
      reg_rd = 1;
      @(negedge clk);
      reg_rd = 0;
      `CHK({reg_hit, reg_rdata}, {a >= 8'h6f && a <= 8'h73, e})
      @(negedge clk);
    end
  endtask
  task tmp(input integer c, input [9:0] r, input [9:0] e);
    begin
      raw_temp[c*10 +: 10] = r;
      raw_valid[c] = 1;
      @(negedge clk);
      raw_valid = 3'h0;
      `CHK({temp_valid[c], temp_corr[c*10 +: 10]}, {1'b1, e})
      @(negedge clk);
    end
  endtask
  // Bounded wait for slot end or conversion start
  task hold(input sd);
    integer i;
    begin
      for (i = 0; i < 300 && (sd ? slot_done : single_channel_convert_start) !== 1'b1; i++) @(negedge clk);
      if (i == 300) begin
        `CHK(i, 0)
        give_verdict;
      end
    end
  endtask
  task slot_len(input integer e);
    integer i;
    begin
      hold(1);
      @(negedge clk);
      k = 0;
      for (i = 0; i < 300 && slot_done !== 1'b1; i++) begin
        k += single_channel_convert_start;
        @(negedge clk);
      end
      if (i == 300) begin
        `CHK(i, 0)
        give_verdict;
      end
      `CHK(k, e)
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    for (k = 8'h6f; k <= 8'h74; k++) rd(k[7:0], 8'h00);
    `CHK({pwm_out, duty_read}, {3'h5, 24'h123456})
    wr(8'h6f, 8'h01);
    `CHK(tree_test_on, 1'b1)
    rd(8'h6f, 8'h01);
    wr(8'h6f, 8'h00);
    `CHK(tree_test_on, 1'b0)
    wr(8'h70, 8'h55);
    wr(8'h71, 8'haa);
    wr(8'h72, 8'h01);
    rd(8'h71, 8'haa);
    tmp(0, 10'h064, 10'h10e);
    tmp(1, 10'h064, 10'h3b8);
    tmp(2, 10'h064, 10'h066);
    tmp(0, 10'h1f4, 10'h1ff);
    tmp(1, 10'h200, 10'h200);
    wr(8'h73, 8'h05);
    `CHK(fan_two_wire_sense, 4'h0)
    low_freq_mode = 1;
    @(negedge clk);
    `CHK(fan_two_wire_sense, 4'h5)
    wr(8'h73, 8'h30);
    `CHK({attenuator_bypass, averaging_off, core_voltage_input}, 3'b110)
    slot_len(1);
    wr(8'h73, 8'h00);
    slot_len(2);
    hold(1);
    @(negedge clk);
    hold(0);
    // Find the current slot in the ring without letting time pass
    for (n = 0; n < 4 && ring_at(n) !== single_channel_convert_chan; n++) begin
    end
    repeat (5) begin
      n = (n + 1) % 5;
      hold(1);
      @(negedge clk);
      hold(0);
      `CHK(single_channel_convert_chan, ring_at(n))
    end
    wr(8'h73, 8'h40);
    `CHK(single_channel_convert, 1'b1)
    for (n = 0; n < 5; n++) begin
      tach1_min_hi = {ring_at(n), 5'h00};
      hold(1);
      @(negedge clk);
      repeat (3) begin
        hold(0);
        `CHK(single_channel_convert_chan, ring_at(n))
        @(negedge clk);
      end
    end
    tach1_min_hi = 8'h60;
    hold(1);
    k = 0;
    repeat (20) begin
      @(negedge clk);
      k += single_channel_convert_start;
    end
    `CHK(k, 0)
    wr(8'h73, 8'h80);
    @(negedge clk);
    `CHK({pwm_out, duty_read}, 27'h0)
    pwm_polarity_invert = 1;
    @(negedge clk);
    `CHK(pwm_out, 3'h7)
    cfg_lock = 1;
    wr(8'h6f, 8'h01);
    `CHK(tree_test_on, 1'b0)
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h55);
    wr(8'h73, 8'h00);
    `CHK(shutdown_request, 1'b1)
    give_verdict;
  end
endmodule // tb
